// ### src/crt_top.sv
// Purpose: clock ready status, fast RC self-tune, reference trim gating
// Assumes: APB slave on pclk; pin-side ticks are asynchronous
// Notes: interrupt requests are levels for an outside controller
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "crt_map.svh"
module crt_top #(
	parameter logic [11:0] TARGET = 12'h0F4
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire crt_pkg::crt_src_t src_in,
	input  wire logic             idle_mode,
	input  wire logic             frc_clk_in,
	input  wire logic             secondary_crystal_ref_in,
	input  wire logic             usb_ref_in,
	input  wire logic             div_switch_done,
	input  wire logic             ref_req_active,
	output logic [5:0]            frc_tune_out,
	output logic [14:0]           ref_div_out,
	output logic [8:0]            ref_frac_out,
	output logic                  lock_irq,
	output logic                  range_irq
);
	import crt_pkg::*;
	// Pin-side synchronisers: three stages, change on stage two/three agree
	logic [2:0] frc_s_r, secondary_crystal_s_r, usb_s_r;
	logic [2:0] frc_s_nxt, secondary_crystal_s_nxt, usb_s_nxt;
	logic       frc_l_r, ref_l_r, frc_l_nxt, ref_l_nxt;
	logic       frc_tick, ref_tick, ref_lvl;
	// Registers
	logic [31:0] status_r, status_nxt;
	logic        tn_on_r, tn_stop_in_idle_r, tn_src_r, tn_pol_r, tn_range_irq_polarity_r;
	logic        tn_on_nxt, tn_stop_in_idle_nxt, tn_src_nxt, tn_pol_nxt, tn_range_irq_polarity_nxt;
	logic        tn_lock_r, tn_tune_out_of_range_r, tn_lock_nxt, tn_tune_out_of_range_nxt;
	logic [5:0]  tun_r, tun_nxt;
	logic        rc_on_r, rc_on_nxt;
	logic [14:0] div_r, div_nxt;
	logic [8:0]  trim_pend_r, trim_pend_nxt, trim_app_r, trim_app_nxt;
	crt_sw_t     sw_r, sw_nxt;
	crt_ul_t     ul_r, ul_nxt;
	logic [31:0] prdata_nxt;
	logic        wr_en, rd_en;
	logic        meter_done;
	logic signed [12:0] meter_err;
	logic        tune_run;
	logic        mag_small;
	logic        over_range;
	logic [12:0] err_abs;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	always_comb begin
		frc_s_nxt  = {frc_s_r[1:0], frc_clk_in};
		secondary_crystal_s_nxt = {secondary_crystal_s_r[1:0], secondary_crystal_ref_in};
		usb_s_nxt  = {usb_s_r[1:0], usb_ref_in};
		ref_lvl    = tn_src_r ? usb_s_r[2] : secondary_crystal_s_r[2];
		frc_l_nxt  = frc_l_r;
		ref_l_nxt  = ref_l_r;
		if (frc_s_r[1] == frc_s_r[2]) begin
			frc_l_nxt = frc_s_r[2];
		end
		if (tn_src_r ? (usb_s_r[1] == usb_s_r[2]) : (secondary_crystal_s_r[1] == secondary_crystal_s_r[2])) begin
			ref_l_nxt = ref_lvl;
		end
		frc_tick = frc_l_nxt && !frc_l_r;
		ref_tick = ref_l_nxt && !ref_l_r;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frc_s_r  <= '0;
			secondary_crystal_s_r <= '0;
			usb_s_r  <= '0;
			frc_l_r  <= 1'b0;
			ref_l_r  <= 1'b0;
		end else if (ce) begin
			frc_s_r  <= frc_s_nxt;
			secondary_crystal_s_r <= secondary_crystal_s_nxt;
			usb_s_r  <= usb_s_nxt;
			frc_l_r  <= frc_l_nxt;
			ref_l_r  <= ref_l_nxt;
		end
	end
	assign tune_run = tn_on_r && !(tn_stop_in_idle_r && idle_mode);
	crt_freq_meter #(.CW(12), .TARGET(TARGET)) u_meter (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.run      (tune_run),
		.frc_tick (frc_tick),
		.ref_tick (ref_tick),
		.done_r   (meter_done),
		.err_r    (meter_err)
	);
	assign err_abs    = meter_err[12] ? 13'(-meter_err) : 13'(meter_err);
	assign mag_small  = err_abs < {7'h00, `CRT_LOCK_TOL};
	assign over_range = err_abs > {1'b0, `CRT_RANGE_LIM};
	// Status: sampled each cycle, inputs come from same-clock logic
	always_comb begin
		status_nxt = '0;
		status_nxt[`CRT_ST_ONE_BIT] = 1'b1;
		status_nxt[`CRT_ST_PLL] = src_in.pll_locked;
		status_nxt[`CRT_ST_USB] = src_in.usb_running;
		status_nxt[`CRT_ST_LOWPOWER_INTERNAL_RC] = src_in.lowpower_internal_rc_en;
		status_nxt[`CRT_ST_SECONDARY_CRYSTAL] = src_in.secondary_crystal_en && src_in.secondary_crystal_expired;
		status_nxt[`CRT_ST_PRIMARY_OSCILLATOR] = src_in.primary_oscillator_en && src_in.primary_oscillator_expired;
		status_nxt[`CRT_ST_PDIV] = src_in.plldiv_en && src_in.pll_expired;
		status_nxt[`CRT_ST_FRC] = src_in.frc_en;
	end
	// Unlock sequencer
	always_comb begin
		ul_nxt = ul_r;
		if (wr_en) begin
			unique case (ul_r)
				CRT_UL_IDLE: begin
					if (paddr == `CRT_OFS_UNLOCK && pwdata == `CRT_UNLOCK_KEY1) ul_nxt = CRT_UL_KEY1;
				end
				CRT_UL_KEY1: begin
					ul_nxt = (paddr == `CRT_OFS_UNLOCK && pwdata == `CRT_UNLOCK_KEY2)
						? CRT_UL_OPEN : CRT_UL_IDLE;
				end
				CRT_UL_OPEN: begin
					if (paddr == `CRT_OFS_TUNE) ul_nxt = CRT_UL_IDLE;
				end
				default: ul_nxt = CRT_UL_IDLE;
			endcase
		end
	end
	// Tuning register and self-tune loop
	always_comb begin
		tn_on_nxt    = tn_on_r;
		tn_stop_in_idle_nxt  = tn_stop_in_idle_r;
		tn_src_nxt   = tn_src_r;
		tn_pol_nxt   = tn_pol_r;
		tn_range_irq_polarity_nxt = tn_range_irq_polarity_r;
		tn_lock_nxt  = tn_lock_r;
		tn_tune_out_of_range_nxt  = tn_tune_out_of_range_r;
		tun_nxt      = tun_r;
		if (wr_en && paddr == `CRT_OFS_TUNE && ul_r == CRT_UL_OPEN) begin
			tn_on_nxt    = pwdata[`CRT_TN_ON];
			tn_stop_in_idle_nxt  = pwdata[`CRT_TN_STOP_IN_IDLE];
			tn_src_nxt   = pwdata[`CRT_TN_SRC];
			tn_pol_nxt   = pwdata[`CRT_TN_POL];
			tn_range_irq_polarity_nxt = pwdata[`CRT_TN_RANGE_IRQ_POLARITY];
			// software owns tuning only when off
			if (!tn_on_r) tun_nxt = pwdata[`CRT_TN_TUN_LSB +: 6];
		end
		if (!tn_on_r) begin
			tn_lock_nxt = 1'b0;
			tn_tune_out_of_range_nxt = 1'b0;
		end else if (tune_run && meter_done) begin
			tn_lock_nxt = mag_small && !over_range;
			tn_tune_out_of_range_nxt = over_range;
			if (!over_range && !mag_small) begin
				if (meter_err[12]) begin
					if (tun_r != `CRT_TUN_MAX) tun_nxt = tun_r + 6'h01;
				end else begin
					if (tun_r != `CRT_TUN_MIN) tun_nxt = tun_r - 6'h01;
				end
			end
		end
	end
	// Reference divider and trim
	always_comb begin
		rc_on_nxt     = rc_on_r;
		div_nxt       = div_r;
		trim_pend_nxt = trim_pend_r;
		trim_app_nxt  = trim_app_r;
		sw_nxt        = sw_r;
		if (wr_en && paddr == `CRT_OFS_TRIM) begin
			trim_pend_nxt = pwdata[`CRT_TR_LSB +: 9];
			if (!rc_on_r) trim_app_nxt = pwdata[`CRT_TR_LSB +: 9];
		end
		unique case (sw_r)
			CRT_SW_IDLE: begin
				if (wr_en && paddr == `CRT_OFS_REFCON) begin
					rc_on_nxt = pwdata[`CRT_RC_ON];
					div_nxt   = pwdata[`CRT_RC_DIV_LSB +: 15];
					if (pwdata[`CRT_RC_SWEN]) sw_nxt = CRT_SW_BUSY;
				end
			end
			CRT_SW_BUSY: begin
				if (div_switch_done) begin
					sw_nxt = CRT_SW_IDLE;
					trim_app_nxt = trim_pend_nxt;
				end
			end
			default: sw_nxt = CRT_SW_IDLE;
		endcase
	end
	// Read mux, data registered in setup phase
	always_comb begin
		prdata_nxt = prdata;
		if (rd_en) begin
			prdata_nxt = '0;
			unique case (paddr)
				`CRT_OFS_STATUS: prdata_nxt = status_r;
				`CRT_OFS_TUNE: begin
					// debugger bit and upper bits zero
					prdata_nxt[`CRT_TN_ON]    = tn_on_r;
					prdata_nxt[`CRT_TN_STOP_IN_IDLE]  = tn_stop_in_idle_r;
					prdata_nxt[`CRT_TN_SRC]   = tn_src_r;
					prdata_nxt[`CRT_TN_LOCK]  = tn_lock_r;
					prdata_nxt[`CRT_TN_POL]   = tn_pol_r;
					prdata_nxt[`CRT_TN_TUNE_OUT_OF_RANGE]  = tn_tune_out_of_range_r;
					prdata_nxt[`CRT_TN_RANGE_IRQ_POLARITY] = tn_range_irq_polarity_r;
					prdata_nxt[`CRT_TN_TUN_LSB +: 6] = tun_r;
				end
				`CRT_OFS_REFCON: begin
					prdata_nxt[`CRT_RC_DIV_LSB +: 15] = div_r;
					prdata_nxt[`CRT_RC_ON]     = rc_on_r;
					prdata_nxt[`CRT_RC_SWEN]   = (sw_r == CRT_SW_BUSY);
					prdata_nxt[`CRT_RC_ACTIVE] = ref_req_active;
				end
				`CRT_OFS_TRIM: prdata_nxt[`CRT_TR_LSB +: 9] = trim_pend_r;
				default: prdata_nxt = '0;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r    <= `CRT_ST_RESET;
			tn_on_r     <= 1'b0;
			tn_stop_in_idle_r   <= 1'b0;
			tn_src_r    <= 1'b0;
			tn_pol_r    <= 1'b0;
			tn_range_irq_polarity_r  <= 1'b0;
			tn_lock_r   <= 1'b0;
			tn_tune_out_of_range_r   <= 1'b0;
			tun_r       <= '0;
			rc_on_r     <= 1'b0;
			div_r       <= '0;
			trim_pend_r <= '0;
			trim_app_r  <= '0;
			sw_r        <= CRT_SW_IDLE;
			ul_r        <= CRT_UL_IDLE;
			prdata      <= '0;
		end else if (ce) begin
			status_r    <= status_nxt;
			tn_on_r     <= tn_on_nxt;
			tn_stop_in_idle_r   <= tn_stop_in_idle_nxt;
			tn_src_r    <= tn_src_nxt;
			tn_pol_r    <= tn_pol_nxt;
			tn_range_irq_polarity_r  <= tn_range_irq_polarity_nxt;
			tn_lock_r   <= tn_lock_nxt;
			tn_tune_out_of_range_r   <= tn_tune_out_of_range_nxt;
			tun_r       <= tun_nxt;
			rc_on_r     <= rc_on_nxt;
			div_r       <= div_nxt;
			trim_pend_r <= trim_pend_nxt;
			trim_app_r  <= trim_app_nxt;
			sw_r        <= sw_nxt;
			ul_r        <= ul_nxt;
			prdata      <= prdata_nxt;
		end
	end
	assign frc_tune_out = tun_r;
	assign ref_div_out  = div_r;
	// fraction is N/512 of one step
	assign ref_frac_out = (div_r == 15'h0000) ? 9'h000 : trim_app_r;
	assign lock_irq  = tn_on_r && (tn_lock_r == !tn_pol_r);
	assign range_irq = tn_on_r && (tn_tune_out_of_range_r == !tn_range_irq_polarity_r);

	a_status_fixed: assert property (@(posedge pclk) disable iff (!presetn)
		status_r[`CRT_ST_ONE_BIT] && !status_r[`CRT_ST_ZERO_BIT] && status_r[31:`CRT_ST_TOP_LSB] == '0)
		else $error("status fixed bits wrong");
	a_primary_oscillator_ready: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> status_r[`CRT_ST_PRIMARY_OSCILLATOR] == $past(src_in.primary_oscillator_en && src_in.primary_oscillator_expired))
		else $error("primary ready mismatch");
	a_secondary_crystal_ready: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> status_r[`CRT_ST_SECONDARY_CRYSTAL] == $past(src_in.secondary_crystal_en && src_in.secondary_crystal_expired))
		else $error("secondary ready mismatch");
	a_pll_lock: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> status_r[`CRT_ST_PLL] == $past(src_in.pll_locked))
		else $error("pll lock flag mismatch");
	a_usb_running: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> status_r[`CRT_ST_USB] == $past(src_in.usb_running))
		else $error("usb running flag mismatch");
	a_lowpower_internal_rc_ready: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> status_r[`CRT_ST_LOWPOWER_INTERNAL_RC] == $past(src_in.lowpower_internal_rc_en))
		else $error("low power rc flag mismatch");
	a_pdiv_ready: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> status_r[`CRT_ST_PDIV] == $past(src_in.plldiv_en && src_in.pll_expired))
		else $error("postscaler ready mismatch");
	a_frc_ready: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> status_r[`CRT_ST_FRC] == $past(src_in.frc_en))
		else $error("fast rc flag mismatch");
	a_frac_zero_div: assert property (@(posedge pclk) disable iff (!presetn)
		div_r == 15'h0000 |-> ref_frac_out == 9'h000)
		else $error("fraction applied with zero divider");
	a_trim_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(rc_on_r && sw_r == CRT_SW_IDLE && ce && !(wr_en && paddr == `CRT_OFS_REFCON))
		|=> $stable(trim_app_r))
		else $error("trim applied without switch");
	a_locked_write: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && wr_en && paddr == `CRT_OFS_TUNE && ul_r != CRT_UL_OPEN) |=> $stable(tn_on_r))
		else $error("tuning write accepted while locked");
	a_switch_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && sw_r == CRT_SW_BUSY && div_switch_done) |=> sw_r == CRT_SW_IDLE)
		else $error("divider switch not cleared");
	a_range_freeze: assert property (@(posedge pclk) disable iff (!presetn)
		(tn_tune_out_of_range_r && !(meter_done && tune_run) && ce && !wr_en) |=> $stable(tun_r))
		else $error("tuning moved while out of range");
	a_idle_stop: assert property (@(posedge pclk) disable iff (!presetn)
		(tn_stop_in_idle_r && idle_mode && ce && !wr_en) |=> $stable(tun_r))
		else $error("tuning moved during idle");
	a_tune_owned: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && tn_on_r && wr_en && paddr == `CRT_OFS_TUNE && !(tune_run && meter_done))
		|=> $stable(tun_r))
		else $error("software wrote tuning while self-tune on");
	a_lock_irq_pol: assert property (@(posedge pclk) disable iff (!presetn)
		tn_on_r |-> lock_irq == (tn_lock_r ^ tn_pol_r))
		else $error("lock interrupt polarity wrong");
	a_range_irq_pol: assert property (@(posedge pclk) disable iff (!presetn)
		tn_on_r |-> range_irq == (tn_tune_out_of_range_r ^ tn_range_irq_polarity_r))
		else $error("range interrupt polarity wrong");
endmodule
`default_nettype wire

// ### src/crt_map.svh
// Purpose: register offsets, field positions and reset values for the clock status and tuning block
// Assumes: APB, 32-bit words, byte addresses
`ifndef CRT_MAP_SVH
`define CRT_MAP_SVH
`define CRT_OFS_STATUS   12'h000
`define CRT_OFS_TUNE     12'h004
`define CRT_OFS_REFCON   12'h008
`define CRT_OFS_TRIM     12'h00C
`define CRT_OFS_UNLOCK   12'h010
`define CRT_OFS_SRC      12'h014
`define CRT_UNLOCK_KEY1  32'hAA996655
`define CRT_UNLOCK_KEY2  32'h556699AA
`define CRT_ST_ONE_BIT   8
`define CRT_ST_ZERO_BIT  3
`define CRT_ST_TOP_LSB   9
`define CRT_ST_RESET     32'h00000100
`define CRT_ST_PLL       7
`define CRT_ST_USB       6
`define CRT_ST_LOWPOWER_INTERNAL_RC      5
`define CRT_ST_SECONDARY_CRYSTAL      4
`define CRT_ST_PRIMARY_OSCILLATOR      2
`define CRT_ST_PDIV      1
`define CRT_ST_FRC       0
`define CRT_TN_ON        15
`define CRT_TN_DBG       14
`define CRT_TN_STOP_IN_IDLE      13
`define CRT_TN_SRC       12
`define CRT_TN_LOCK      11
`define CRT_TN_POL       10
`define CRT_TN_TUNE_OUT_OF_RANGE      9
`define CRT_TN_RANGE_IRQ_POLARITY     8
`define CRT_TN_TUN_LSB   0
`define CRT_RC_ON        15
`define CRT_RC_SWEN      9
`define CRT_RC_ACTIVE    8
`define CRT_RC_DIV_LSB   16
`define CRT_TR_LSB       23
`define CRT_LOCK_TOL     6'h02
`define CRT_RANGE_LIM    12'h0FF
`define CRT_TUN_MAX      6'h1F
`define CRT_TUN_MIN      6'h20
`endif

// ### src/crt_pkg.sv
// Purpose: shared types for the clock status and tuning block
// Assumes: nothing
// Notes: clock source flags travel as one struct
package crt_pkg;
	typedef struct packed {
		logic pll_locked;
		logic usb_running;
		logic lowpower_internal_rc_en;
		logic secondary_crystal_en;
		logic secondary_crystal_expired;
		logic primary_oscillator_en;
		logic primary_oscillator_expired;
		logic plldiv_en;
		logic pll_expired;
		logic frc_en;
	} crt_src_t;
	typedef enum logic [1:0] {
		CRT_UL_IDLE = 2'b00,
		CRT_UL_KEY1 = 2'b01,
		CRT_UL_OPEN = 2'b11
	} crt_ul_t;
	typedef enum logic [1:0] {
		CRT_SW_IDLE = 2'b00,
		CRT_SW_BUSY = 2'b01
	} crt_sw_t;
endpackage

// ### src/crt_freq_meter.sv
// Purpose: counts fast RC edges over one reference window, reports error
// Assumes: both tick inputs are already synchronised one-cycle pulses
// Notes: window is one reference period; expected edge count TARGET is a parameter
`timescale 1ns/1ps
`default_nettype none
module crt_freq_meter #(
	parameter int          CW     = 12,
	parameter logic [11:0] TARGET = 12'h0F4
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          ce,
	input  wire logic          run,
	input  wire logic          frc_tick,
	input  wire logic          ref_tick,
	output logic               done_r,
	output logic signed [12:0] err_r
);
	logic [CW-1:0]      cnt_r;
	logic [CW-1:0]      cnt_nxt;
	logic               done_nxt;
	logic signed [12:0] err_nxt;
	logic               armed_r;
	logic               armed_nxt;
	always_comb begin
		cnt_nxt   = cnt_r;
		done_nxt  = 1'b0;
		err_nxt   = err_r;
		armed_nxt = armed_r;
		// First edge after start only arms: a partial window would mis-step tuning
		if (!run) begin
			cnt_nxt   = '0;
			armed_nxt = 1'b0;
		end else if (ref_tick) begin
			if (armed_r) begin
				// Positive error means fast RC runs fast
				err_nxt  = $signed({1'b0, cnt_r}) - $signed({1'b0, TARGET});
				done_nxt = 1'b1;
			end
			armed_nxt = 1'b1;
			cnt_nxt   = '0;
		end else if (frc_tick) begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r   <= '0;
			done_r  <= 1'b0;
			err_r   <= '0;
			armed_r <= 1'b0;
		end else if (ce) begin
			cnt_r   <= cnt_nxt;
			done_r  <= done_nxt;
			err_r   <= err_nxt;
			armed_r <= armed_nxt;
		end
	end
endmodule
`default_nettype wire

// ### dv/crt_top_tb.sv
// Purpose: self-checking bench for clock status, self-tune and trim gating
// Assumes: APB answer waited on pready; pin clocks derived from pclk
// Notes: TARGET cut to 16 edges so tuning windows stay short
`timescale 1ns/1ps
`default_nettype none
`include "crt_map.svh"
module crt_top_tb;
	logic              pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic              idle_mode, frc_clk_in, secondary_crystal_ref_in, usb_ref_in;
	logic              div_switch_done, ref_req_active, lock_irq, range_irq;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, rd;
	crt_pkg::crt_src_t src_in;
	logic [5:0]        frc_tune_out;
	logic [14:0]       ref_div_out;
	logic [8:0]        ref_frac_out;
	int                bad_count, check_count, cyc, uc, usb_half;
	localparam logic [31:0] ALL  = 32'hFFFFFFFF;
	// Bit 14 belongs to the debugger, so never compared
	localparam logic [31:0] TMSK = 32'hFFFFBFFF;

	crt_top #(.TARGET(12'h010)) uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_in(src_in), .idle_mode(idle_mode),
		.frc_clk_in(frc_clk_in), .secondary_crystal_ref_in(secondary_crystal_ref_in), .usb_ref_in(usb_ref_in),
		.div_switch_done(div_switch_done), .ref_req_active(ref_req_active),
		.frc_tune_out(frc_tune_out), .ref_div_out(ref_div_out), .ref_frac_out(ref_frac_out),
		.lock_irq(lock_irq), .range_irq(range_irq));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Fast RC 4 cycles, slow reference 16 of those, USB reference adjustable
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		frc_clk_in <= cyc[1];
		secondary_crystal_ref_in <= cyc[5];
		if (uc >= usb_half - 1) begin
			uc <= 0;
			usb_ref_in <= ~usb_ref_in;
		end else begin
			uc <= uc + 1;
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		chk("slave error", 32'h0, pslverr);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
		input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd & m);
	endtask

	// Unlock immediately before every tuning write
	task automatic tune_wr(input logic [31:0] d);
		wr(`CRT_OFS_UNLOCK, `CRT_UNLOCK_KEY1);
		wr(`CRT_OFS_UNLOCK, `CRT_UNLOCK_KEY2);
		wr(`CRT_OFS_TUNE, d); // software side
	endtask

	task automatic test_status;
		crt_pkg::crt_src_t s;
		logic [31:0]       e;
		rdc(`CRT_OFS_STATUS, 32'h00000100, ALL, "status reset"); // reset
		for (int i = 0; i <= 10; i++) begin
			s = (i < 10) ? crt_pkg::crt_src_t'(10'h001 << i) : crt_pkg::crt_src_t'(10'h3FF);
			src_in <= s;
			e = {24'h000001, s.pll_locked, s.usb_running, s.lowpower_internal_rc_en, s.secondary_crystal_en & s.secondary_crystal_expired,
				1'b0, s.primary_oscillator_en & s.primary_oscillator_expired, s.plldiv_en & s.pll_expired, s.frc_en};
			repeat (2) @(posedge pclk);
			if (i == 10) wr(`CRT_OFS_STATUS, ALL);
			rdc(`CRT_OFS_STATUS, e, ALL, "status"); // flags
			chk("status low", e, rd); // flags
		end
		src_in <= '0;
		$display("status test finished");
	endtask

	task automatic test_tune_access;
		tune_wr(32'hFFFF7FFF);
		rdc(`CRT_OFS_TUNE, 32'h0000353F, TMSK, "tune fields"); // fields
		chk("tune out", 32'h3F, frc_tune_out); // top code
		wr(`CRT_OFS_TUNE, 32'h0);
		rdc(`CRT_OFS_TUNE, 32'h0000353F, TMSK, "tune locked"); // no unlock
		wr(`CRT_OFS_UNLOCK, `CRT_UNLOCK_KEY1);
		wr(`CRT_OFS_STATUS, 32'h0);
		wr(`CRT_OFS_UNLOCK, `CRT_UNLOCK_KEY2);
		wr(`CRT_OFS_TUNE, 32'h0);
		rdc(`CRT_OFS_TUNE, 32'h0000353F, TMSK, "tune aborted"); // broken sequence
		tune_wr(32'h0);
		wr(`CRT_OFS_TUNE, 32'h1);
		rdc(`CRT_OFS_TUNE, 32'h0, TMSK, "tune consumed"); // one write only
		wr(12'h020, ALL);
		rdc(12'h020, 32'h0, ALL, "unmapped");
		$display("tune access test finished");
	endtask

	task automatic test_lock_irq;
		logic [31:0] v;
		for (int k = 0; k < 4; k++) begin
			v = 32'h8000 | {21'h0, k[1], 1'b0, k[0], 8'h00};
			tune_wr(v);
			repeat (600) @(posedge pclk);
			rdc(`CRT_OFS_TUNE, v | 32'h0800, 32'hFFFFBFC0, "lock"); // locked
			chk("lock irq", {31'h0, ~k[1]}, lock_irq); // polarity
			chk("range irq", {31'h0, k[0]}, range_irq); // polarity
		end
		$display("lock interrupt test finished");
	endtask

	task automatic test_selftune;
		// Reference picked while tuning is off, so no stray edge is measured
		usb_half = 600;
		tune_wr(32'h00001005);
		tune_wr(32'h00009005);
		repeat (4000) @(posedge pclk);
		rdc(`CRT_OFS_TUNE, 32'h00009205, TMSK, "out of range"); // tuning frozen
		chk("range irq set", 32'h1, range_irq); // active
		chk("lock irq clear", 32'h0, lock_irq); // unlocked
		tune_wr(32'h0);
		usb_half = 80;
		idle_mode <= 1'b1;
		tune_wr(32'h0000B000);
		repeat (1000) @(posedge pclk);
		chk("idle hold", 32'h0, frc_tune_out); // stopped in idle
		idle_mode <= 1'b0;
		repeat (7000) @(posedge pclk);
		rdc(`CRT_OFS_TUNE, 32'h0000B020, TMSK, "tuned down"); // lowest
		tune_wr(32'h0);
		$display("self tune test finished");
	endtask

	task automatic test_trim;
		wr(`CRT_OFS_REFCON, 32'h0);
		wr(`CRT_OFS_TRIM, 32'hFF800000); // enable equals active
		chk("frac div zero", 32'h0, ref_frac_out); // ignored
		rdc(`CRT_OFS_TRIM, 32'hFF800000, ALL, "trim rw");
		wr(`CRT_OFS_REFCON, 32'h00050000);
		chk("div", 32'h5, ref_div_out);
		chk("frac", 32'h1FF, ref_frac_out); // applied
		ref_req_active <= 1'b1;
		wr(`CRT_OFS_REFCON, 32'h00058000);
		rdc(`CRT_OFS_REFCON, 32'h00058100, ALL, "refcon on");
		wr(`CRT_OFS_TRIM, 32'h55000000); // enable equals active
		chk("frac held", 32'h1FF, ref_frac_out); // waits for switch
		wr(`CRT_OFS_REFCON, 32'h00038200);
		rdc(`CRT_OFS_REFCON, 32'h00038300, ALL, "switch busy"); // in progress
		chk("frac busy", 32'h1FF, ref_frac_out); // still held
		div_switch_done <= 1'b1;
		@(posedge pclk);
		div_switch_done <= 1'b0;
		repeat (3) @(posedge pclk);
		rdc(`CRT_OFS_REFCON, 32'h00038100, ALL, "switch done"); // cleared
		chk("frac new", 32'h0AA, ref_frac_out); // applied
		chk("div new", 32'h3, ref_div_out);
		// Clock enable low: a register write must not land
		ce <= 1'b0;
		wr(`CRT_OFS_REFCON, 32'h00070000);
		ce <= 1'b1;
		chk("div frozen", 32'h3, ref_div_out);
		$display("trim test finished");
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		{presetn, psel, penable, pwrite, idle_mode, div_switch_done, ref_req_active} = '0;
		{frc_clk_in, secondary_crystal_ref_in, usb_ref_in} = '0;
		// Clock enable high except in the freeze check
		ce = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h0;
		src_in = '0;
		{bad_count, check_count, cyc, uc} = '0;
		usb_half = 80;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		test_status();
		test_tune_access();
		test_lock_irq();
		test_selftune();
		test_trim();
		results();
	end

	// Whole run needs about 14700 cycles
	initial begin
		repeat (40000) @(posedge pclk);
		bad_count++;
		results();
	end
endmodule
`default_nettype wire
